/* File: bpp_ports.sv */
// general-purpose pin ports: one 4-bit port and two 8-bit ports
`include "bpp_regs.svh"
module bpp_ports #(
	parameter bit HAS_SECOND_PORT = 1'b1
) (
	input  wire logic       clk_i,
	input  wire logic       resetn_i,
	input  wire logic       reg_wr_i,
	input  wire logic       reg_rd_i,
	input  wire logic [4:0] reg_addr_i,
	input  wire logic [7:0] reg_wdata_i,
	input  wire logic       dir_load_i,
	input  wire logic [1:0] dir_sel_i,
	output logic      [7:0] reg_rdata_o,
	output logic            reg_hit_o,
	output logic            cycle_start_o,
	input  wire logic [3:0] narrow_port_pins_i,
	output logic      [3:0] narrow_port_pins_o,
	output logic      [3:0] narrow_port_pins_oe_o,
	input  wire logic [7:0] first_wide_port_pins_i,
	output logic      [7:0] first_wide_port_pins_o,
	output logic      [7:0] first_wide_port_pins_oe_o,
	input  wire logic [7:0] second_wide_port_pins_i,
	output logic      [7:0] second_wide_port_pins_o,
	output logic      [7:0] second_wide_port_pins_oe_o
);
	// same time units as the bench, so no unit is left to tool defaults
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct packed {
		bpp_pkg::bpp_phase_e phase;
		logic                cyc_start;
		logic [7:0]          rdata;
		logic                hit;
		logic [7:0]          gp_reg;
	} top_s;

	top_s st_r;
	top_s st_nxt;

	logic       cycle_end;
	logic       cycle_start;
	logic       wr_narrow;
	logic       wr_first;
	logic       wr_second;
	logic       dl_narrow;
	logic       dl_first;
	logic       dl_second;
	logic [3:0] rd_narrow;
	logic [7:0] rd_first;
	logic [7:0] rd_second;

	// four clocks make one instruction cycle; enables mark its edges
	assign cycle_end   = (st_r.phase == bpp_pkg::BPP_PH_Q4);
	assign cycle_start = (st_r.phase == bpp_pkg::BPP_PH_Q1);

	// address and selector decode
	assign wr_narrow = reg_wr_i && (reg_addr_i == `BPP_NARROW_PORT_ADDR);
	assign wr_first  = reg_wr_i && (reg_addr_i == `BPP_FIRST_WIDE_ADDR);
	assign wr_second = reg_wr_i && (reg_addr_i == `BPP_SECOND_WIDE_ADDR) && HAS_SECOND_PORT;
	assign dl_narrow = dir_load_i && (dir_sel_i == 2'(bpp_pkg::BPP_SEL_NARROW));
	assign dl_first  = dir_load_i && (dir_sel_i == 2'(bpp_pkg::BPP_SEL_FIRST));
	assign dl_second = dir_load_i && (dir_sel_i == 2'(bpp_pkg::BPP_SEL_SECOND)) && HAS_SECOND_PORT;

	bpp_pin_port #(.WIDTH(`BPP_NARROW_WIDTH)) u_narrow (
		.clk_i         (clk_i),
		.resetn_i      (resetn_i),
		.cycle_end_i   (cycle_end),
		.cycle_start_i (cycle_start),
		.wr_i          (wr_narrow),
		.dir_load_i    (dl_narrow),
		.wdata_i       (reg_wdata_i[3:0]),
		.pin_i         (narrow_port_pins_i),
		.pin_o         (narrow_port_pins_o),
		.pin_oe_o      (narrow_port_pins_oe_o),
		.rdata_o       (rd_narrow)
	);

	bpp_pin_port #(.WIDTH(`BPP_WIDE_WIDTH)) u_first (
		.clk_i         (clk_i),
		.resetn_i      (resetn_i),
		.cycle_end_i   (cycle_end),
		.cycle_start_i (cycle_start),
		.wr_i          (wr_first),
		.dir_load_i    (dl_first),
		.wdata_i       (reg_wdata_i),
		.pin_i         (first_wide_port_pins_i),
		.pin_o         (first_wide_port_pins_o),
		.pin_oe_o      (first_wide_port_pins_oe_o),
		.rdata_o       (rd_first)
	);

	// on the small variant the second port is never written or loaded, so it stays floating
	bpp_pin_port #(.WIDTH(`BPP_WIDE_WIDTH)) u_second (
		.clk_i         (clk_i),
		.resetn_i      (resetn_i),
		.cycle_end_i   (cycle_end),
		.cycle_start_i (cycle_start),
		.wr_i          (wr_second),
		.dir_load_i    (dl_second),
		.wdata_i       (reg_wdata_i),
		.pin_i         (second_wide_port_pins_i),
		.pin_o         (second_wide_port_pins_o),
		.pin_oe_o      (second_wide_port_pins_oe_o),
		.rdata_o       (rd_second)
	);

	// phase counter, read mux and plain data register
	always_comb begin
		st_nxt           = st_r;
		st_nxt.cyc_start = (st_r.phase == bpp_pkg::BPP_PH_Q4);
		case (st_r.phase)
			bpp_pkg::BPP_PH_Q1: st_nxt.phase = bpp_pkg::BPP_PH_Q2;
			bpp_pkg::BPP_PH_Q2: st_nxt.phase = bpp_pkg::BPP_PH_Q3;
			bpp_pkg::BPP_PH_Q3: st_nxt.phase = bpp_pkg::BPP_PH_Q4;
			default:            st_nxt.phase = bpp_pkg::BPP_PH_Q1;
		endcase
		// small variant: address acts as an ordinary storage byte
		if (!HAS_SECOND_PORT && reg_wr_i && cycle_end && (reg_addr_i == `BPP_SECOND_WIDE_ADDR)) begin
			st_nxt.gp_reg = reg_wdata_i;
		end
		st_nxt.hit = 1'b0;
		// direction registers have no read path at all
		if (reg_rd_i) begin
			case (reg_addr_i)
				`BPP_NARROW_PORT_ADDR: begin
					st_nxt.rdata = {`BPP_NARROW_UNUSED, rd_narrow};
					st_nxt.hit   = 1'b1;
				end
				`BPP_FIRST_WIDE_ADDR: begin
					st_nxt.rdata = rd_first;
					st_nxt.hit   = 1'b1;
				end
				`BPP_SECOND_WIDE_ADDR: begin
					st_nxt.rdata = HAS_SECOND_PORT ? rd_second : st_r.gp_reg;
					st_nxt.hit   = 1'b1;
				end
				default: begin
					st_nxt.rdata = 8'h00;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign reg_rdata_o   = st_r.rdata;
	assign reg_hit_o     = st_r.hit;
	assign cycle_start_o = st_r.cyc_start;
endmodule

/* File: bpp_regs.svh */
// register offsets, reset values and timing counts of the pin ports
`ifndef BPP_REGS_SVH
`define BPP_REGS_SVH

`define BPP_NARROW_PORT_ADDR     5'h05
`define BPP_FIRST_WIDE_ADDR      5'h06
`define BPP_SECOND_WIDE_ADDR     5'h07
`define BPP_NARROW_WIDTH         4
`define BPP_WIDE_WIDTH           8
`define BPP_DIR_RESET            8'hFF
`define BPP_NARROW_UNUSED        4'h0
`define BPP_CLK_NS               50
`define BPP_INSTR_NS             200
`define BPP_CLKS_PER_INSTR       (`BPP_INSTR_NS / `BPP_CLK_NS)

`endif

/* File: bpp_pkg.sv */
// types shared by the pin port block
package bpp_pkg;
	// same time units as the bench, so no unit is left to tool defaults
	timeunit 1ns;
	timeprecision 1ps;

	typedef logic [7:0] bpp_byte_t;

	// port selector carried by the direction-load instruction
	typedef enum logic [1:0] {
		BPP_SEL_NARROW,
		BPP_SEL_FIRST,
		BPP_SEL_SECOND,
		BPP_SEL_NONE
	} bpp_sel_e;

	// instruction-cycle phase
	typedef enum logic [1:0] {
		BPP_PH_Q1,
		BPP_PH_Q2,
		BPP_PH_Q3,
		BPP_PH_Q4
	} bpp_phase_e;
endpackage

/* File: bpp_pin_port.sv */
// one pin port: output latch, direction register, pin synchroniser
`include "bpp_regs.svh"
module bpp_pin_port #(
	parameter int WIDTH = 8
) (
	input  wire logic             clk_i,
	input  wire logic             resetn_i,
	input  wire logic             cycle_end_i,
	input  wire logic             cycle_start_i,
	input  wire logic             wr_i,
	input  wire logic             dir_load_i,
	input  wire logic [WIDTH-1:0] wdata_i,
	input  wire logic [WIDTH-1:0] pin_i,
	output logic      [WIDTH-1:0] pin_o,
	output logic      [WIDTH-1:0] pin_oe_o,
	output logic      [WIDTH-1:0] rdata_o
);
	// same time units as the bench, so no unit is left to tool defaults
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct packed {
		logic [WIDTH-1:0] latch;
		logic [WIDTH-1:0] dir;
		logic [WIDTH-1:0] sync1;
		logic [WIDTH-1:0] sync2;
		logic [WIDTH-1:0] sample;
		logic [WIDTH-1:0] oe;
	} port_s;

	port_s st_r;
	port_s st_nxt;

	// next-state logic
	always_comb begin
		st_nxt       = st_r;
		st_nxt.sync1 = pin_i;
		st_nxt.sync2 = st_r.sync1;
		// pins are not latched; level taken fresh at each cycle start
		if (cycle_start_i) begin
			st_nxt.sample = st_r.sync2;
		end
		// latch loads even when the pin is an input
		if (wr_i && cycle_end_i) begin
			st_nxt.latch = wdata_i;
		end
		if (dir_load_i && cycle_end_i) begin
			st_nxt.dir = wdata_i;
		end
		// one direction bit per pin; a set bit floats the pin
		st_nxt.oe = ~st_nxt.dir;
	end

	// state register; direction resets to all inputs
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st_r        <= '0;
			st_r.dir    <= WIDTH'(`BPP_DIR_RESET);
		end else begin
			st_r <= st_nxt;
		end
	end

	assign pin_o    = st_r.latch;
	assign pin_oe_o = st_r.oe;
	assign rdata_o  = st_r.sample;
endmodule

/* File: bpp_ports_sva.sv */
// assertions on the pin port block
module bpp_ports_sva (
	input wire logic       clk_i,
	input wire logic       resetn_i,
	input wire logic       reg_wr_i,
	input wire logic       reg_rd_i,
	input wire logic [4:0] reg_addr_i,
	input wire logic       dir_load_i,
	input wire logic [1:0] dir_sel_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic       reg_hit_o,
	input wire logic       cycle_start_o,
	input wire logic [3:0] narrow_port_pins_oe_o,
	input wire logic [7:0] first_wide_port_pins_o,
	input wire logic [7:0] first_wide_port_pins_oe_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (!resetn_i);
	// three quiet phases between instruction starts
	sequence s_gap;
		!cycle_start_o [*3];
	endsequence
	property p_cyc;
		cycle_start_o |=> s_gap ##1 cycle_start_o;
	endproperty
	a_cyc: assert property (p_cyc) else $error("instruction cycle length wrong");
	property p_hit;
		reg_rd_i && reg_addr_i inside {5'h05, 5'h06, 5'h07} |=> reg_hit_o;
	endproperty
	a_hit: assert property (p_hit) else $error("port read not answered");
	property p_miss;
		reg_rd_i && !(reg_addr_i inside {5'h05, 5'h06, 5'h07}) |=> !reg_hit_o && reg_rdata_o == 8'h00;
	endproperty
	a_miss: assert property (p_miss) else $error("unmapped read answered");
	property p_narrow;
		reg_rd_i && reg_addr_i == 5'h05 |=> reg_rdata_o[7:4] == 4'h0;
	endproperty
	a_narrow: assert property (p_narrow) else $error("narrow port upper bits set");
	property p_hit_src;
		reg_hit_o |-> $past(reg_rd_i);
	endproperty
	a_hit_src: assert property (p_hit_src) else $error("hit without read");
	property p_oe_src;
		$changed(first_wide_port_pins_oe_o) |-> $past(dir_load_i) || $past(dir_load_i, 2);
	endproperty
	a_oe_src: assert property (p_oe_src) else $error("direction moved without load");
	property p_out_src;
		$changed(first_wide_port_pins_o) |-> $past(reg_wr_i) || $past(reg_wr_i, 2);
	endproperty
	a_out_src: assert property (p_out_src) else $error("latch moved without write");
	property p_sel;
		$changed(narrow_port_pins_oe_o) |-> $past(dir_sel_i) == 2'h0 || $past(dir_sel_i, 2) == 2'h0;
	endproperty
	a_sel: assert property (p_sel) else $error("narrow direction loaded by other port");
endmodule
bind bpp_ports bpp_ports_sva i_sva (.*);

/* File: bpp_pin_model.sv */
// outside circuitry on the pins: resolves each pin level
module bpp_pin_model (
	input  wire logic [19:0] oe_i,
	input  wire logic [19:0] drv_i,
	input  wire logic [19:0] ext_i,
	output logic      [19:0] lvl_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// outside drives only floating pins, so no contention with the device
	assign lvl_o = (drv_i & oe_i) | (ext_i & ~oe_i);
endmodule

/* File: tb.sv */
// self-checking bench for the pin ports
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_i = 0, resetn_i = 0, reg_wr_i = 0, reg_rd_i = 0, dir_load_i = 0, reg_hit_o, cycle_start_o;
	logic [4:0]  reg_addr_i = 5'h00;
	logic [7:0]  reg_wdata_i = 8'h00, reg_rdata_o;
	logic [1:0]  dir_sel_i = 2'h3;
	logic [19:0] ext = 20'h00000;
	wire  [19:0] drv, oe, lvl;
	logic [7:0]  small_rdata, small_oe;
	int          fails = 0, samples_checked = 0;
	initial forever #25 clk_i = ~clk_i;
	bpp_pin_model i_pins (.oe_i(oe), .drv_i(drv), .ext_i(ext), .lvl_o(lvl));
	bpp_ports i_dut (.clk_i(clk_i), .resetn_i(resetn_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .dir_load_i(dir_load_i), .dir_sel_i(dir_sel_i),
		.reg_rdata_o(reg_rdata_o), .reg_hit_o(reg_hit_o), .cycle_start_o(cycle_start_o),
		.narrow_port_pins_i(lvl[19:16]), .narrow_port_pins_o(drv[19:16]), .narrow_port_pins_oe_o(oe[19:16]),
		.first_wide_port_pins_i(lvl[15:8]), .first_wide_port_pins_o(drv[15:8]), .first_wide_port_pins_oe_o(oe[15:8]),
		.second_wide_port_pins_i(lvl[7:0]), .second_wide_port_pins_o(drv[7:0]), .second_wide_port_pins_oe_o(oe[7:0]));
	// small variant on the same bus; its 07h pins carry a level that must never be read back
	bpp_ports #(.HAS_SECOND_PORT(1'b0)) i_dut_small (.clk_i(clk_i), .resetn_i(resetn_i), .reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .dir_load_i(dir_load_i),
		.dir_sel_i(dir_sel_i), .reg_rdata_o(small_rdata), .reg_hit_o(), .cycle_start_o(),
		.narrow_port_pins_i(4'h0), .narrow_port_pins_o(), .narrow_port_pins_oe_o(),
		.first_wide_port_pins_i(8'h00), .first_wide_port_pins_o(), .first_wide_port_pins_oe_o(),
		.second_wide_port_pins_i(8'hC3), .second_wide_port_pins_o(), .second_wide_port_pins_oe_o(small_oe));
	task chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	// held four clocks so exactly one cycle-end edge falls inside
	task op(input logic w, input logic r, input logic d, input logic [1:0] s, input logic [4:0] a, input logic [7:0] v);
		repeat (8) @(posedge clk_i);
		reg_wr_i <= w;
		reg_rd_i <= r;
		dir_load_i <= d;
		dir_sel_i <= s;
		reg_addr_i <= a;
		reg_wdata_i <= v;
		repeat (4) @(posedge clk_i);
		reg_wr_i <= 1'b0;
		reg_rd_i <= 1'b0;
		dir_load_i <= 1'b0;
		repeat (2) @(posedge clk_i);
	endtask
	task t_reset;
		chk(oe[15:8] | oe[7:0] | {4'h0, oe[19:16]}, 8'h00, "oe after reset");
		$display("reset test done");
	endtask
	task t_first;
		op(1, 0, 0, 2'h3, 5'h06, 8'hA5);
		chk(drv[15:8], 8'hA5, "latch of input pins");
		chk(oe[15:8], 8'h00, "oe before load");
		op(0, 0, 1, 2'h1, 5'h00, 8'h0F);
		chk(oe[15:8], 8'hF0, "mixed oe");
		ext[15:8] <= 8'h3C;
		op(0, 1, 0, 2'h3, 5'h06, 8'h00);
		chk(reg_rdata_o, 8'hAC, "pin read");
		ext[15:8] <= 8'hC3;
		op(0, 1, 0, 2'h3, 5'h06, 8'h00);
		chk(reg_rdata_o, 8'hA3, "live read");
		$display("first port test done");
	endtask
	task t_narrow;
		op(0, 0, 1, 2'h0, 5'h00, 8'hF0);
		op(1, 0, 0, 2'h3, 5'h05, 8'hF6);
		op(0, 1, 0, 2'h3, 5'h05, 8'h00);
		chk(reg_rdata_o, 8'h06, "narrow read");
		chk(oe[15:8], 8'hF0, "other oe kept");
		$display("narrow port test done");
	endtask
	task t_second;
		op(0, 0, 1, 2'h2, 5'h00, 8'h00);
		chk(small_oe, 8'h00, "small variant oe");
		op(1, 0, 0, 2'h3, 5'h07, 8'h5A);
		op(0, 1, 0, 2'h3, 5'h07, 8'h00);
		chk(reg_rdata_o, 8'h5A, "second read");
		chk(small_rdata, 8'h5A, "small variant storage");
		op(0, 0, 1, 2'h3, 5'h00, 8'hFF);
		chk(oe[7:0], 8'hFF, "no-port load");
		op(0, 1, 0, 2'h3, 5'h1F, 8'h00);
		chk(reg_rdata_o, 8'h00, "unmapped read");
		$display("second port test done");
	endtask
	// reset again after setup left drivers on; every pin must float once more
	task t_rerst;
		resetn_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		resetn_i <= 1'b1;
		@(posedge clk_i);
		chk(oe[15:8] | oe[7:0] | {4'h0, oe[19:16]} | small_oe, 8'h00, "oe after second reset");
		$display("second reset test done");
	endtask
	task wrap_up;
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// sequence needs under two hundred clocks; this is far beyond
	initial begin
		repeat (3000) @(posedge clk_i);
		fails++;
		wrap_up;
	end
	initial begin
		repeat (10) @(posedge clk_i);
		resetn_i <= 1'b1;
		@(posedge clk_i);
		t_reset;
		t_first;
		t_narrow;
		t_second;
		t_rerst;
		wrap_up;
	end
endmodule
